// ### ppim_top.sv
// panel process image map: axi4-lite register bank for keys, inputs, leds and fail-safe image
// Notes on behaviour
// [RULE1] standard input and output image kept apart from the fail-safe image
// [RULE2] input byte 0 bit n reports key n
// [RULE3] input byte 1 bit n reports standard input n
// [RULE4] output bytes 0..2 are red, green, blue planes; byte 3 digital outputs
// [RULE5] rgb 100 red, 010 green, 001 blue, 110 yellow, 111 white, others off
// [RULE6] inputs reserved for fail-safe read as zero in the standard image
// [RULE7] fail-safe image has five input and four output bytes from a base
// [RULE8] first fail-safe byte: bits unused by the evaluation read zero
// [RULE9] no evaluation configured: first fail-safe byte carries nothing
// [RULE10] single channel: bit 4 is safety input zero, bit 5 safety input one
// [RULE11] dual channel: bit 0 high only when both channels report released
// [RULE12] inputs sampled every cycle, written outputs applied at once
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module ppim_top
  import ppim_pkg::*;
#(
  parameter int NUM_KEYS = 8,
  parameter int NUM_IO   = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // axi4-lite write address
  input  wire logic [7:0]    s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [7:0]    s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  // panel pins
  input  wire logic [7:0]    key_pin_i,
  input  wire logic [7:0]    standard_input_bit_i,
  input  wire logic          safety_input_zero_i,
  input  wire logic          safety_input_one_i,
  // panel drive
  output logic [23:0]        led_color_o,
  output logic [7:0]         digital_output_o,
  output logic [31:0]        safety_output_o,
  // interrupt
  output logic               irq_o
);
  initial begin
    if (NUM_KEYS != 8 || NUM_IO != 8) $error("ppim_top: image bytes serve exactly 8 keys and 8 io");
  end

  // ******************************************
  // pin synchronisers
  // ******************************************
  logic [7:0] key_sync;
  logic [7:0] din_sync;
  logic [7:0] safe_sync;

  ppim_sync #(.WIDTH(8)) u_key_sync (.clk_i(clk_i), .nrst_i(nrst_i), .async_i(key_pin_i), .sync_o(key_sync));
  ppim_sync #(.WIDTH(8)) u_din_sync (.clk_i(clk_i), .nrst_i(nrst_i), .async_i(standard_input_bit_i),
                                     .sync_o(din_sync));
  ppim_sync #(.WIDTH(8)) u_safe_sync (.clk_i(clk_i), .nrst_i(nrst_i),
                                      .async_i({6'h00, safety_input_one_i, safety_input_zero_i}),
                                      .sync_o(safe_sync));

  // ******************************************
  // control registers
  // ******************************************
  logic [15:0]         cfg_reg;
  logic [7:0]          red_reg;
  logic [7:0]          green_reg;
  logic [7:0]          blue_reg;
  logic [7:0]          dout_reg;
  logic [31:0]         safe_out_reg;
  logic [PPIM_IRQ_W-1:0] irq_stat_reg;
  logic [PPIM_IRQ_W-1:0] irq_mask_reg;
  ppim_eval_t          eval_mode;
  logic [7:0]          safe_assign;

  assign eval_mode   = ppim_eval_t'(cfg_reg[PPIM_CFG_MODE_LSB +: 2]);
  assign safe_assign = cfg_reg[PPIM_CFG_ASSIGN_LSB +: 8];

  // ******************************************
  // input image
  // ******************************************
  logic [7:0] key_img_reg;
  logic [7:0] din_img_reg;
  logic [7:0] safe_img_reg;
  logic [7:0] safe_img_next;

  always_comb begin
    safe_img_next = 8'h00;                                       // [RULE8] [RULE9]
    unique case (eval_mode)
      PPIM_EVAL_SINGLE: begin
        safe_img_next[PPIM_SAFE_ZERO_BIT] = safe_sync[0];        // [RULE10]
        safe_img_next[PPIM_SAFE_ONE_BIT]  = safe_sync[1];        // [RULE10]
      end
      PPIM_EVAL_DUAL: begin
        // a discrepancy between channels counts as a fault and reads pressed
        safe_img_next[PPIM_SAFE_ESTOP_BIT] = safe_sync[0] & safe_sync[1];  // [RULE11]
      end
      default: safe_img_next = 8'h00;                            // [RULE9]
    endcase
  end

  // refreshed every clock so a read always sees the newest state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_img_reg  <= PPIM_RST_BYTE;
      din_img_reg  <= PPIM_RST_BYTE;
      safe_img_reg <= PPIM_RST_BYTE;
    end else begin
      key_img_reg  <= key_sync;                                  // [RULE2] [RULE12]
      din_img_reg  <= din_sync & ~safe_assign;                   // [RULE3] [RULE6]
      safe_img_reg <= safe_img_next;                             // [RULE1] [RULE12]
    end
  end

  // ******************************************
  // axi4-lite write channel
  // ******************************************
  logic       aw_held_reg;
  logic       w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_fire;
  logic       wr_hit;

  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;

  function automatic logic addr_writable(input logic [7:0] a);
    addr_writable = (a >= PPIM_A_LED_RED && a <= PPIM_A_SAFE_OUT3 && a[1:0] == 2'h0) ||
                    a == PPIM_A_CONFIG || a == PPIM_A_IRQ_STATUS || a == PPIM_A_IRQ_MASK;
  endfunction

  assign wr_hit = addr_writable(aw_addr_reg);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // ready only while the slot is empty: one write in flight at a time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= ~aw_held_reg & ~(s_axi_awvalid_i & s_axi_awready_o) & ~s_axi_bvalid_o & ~wr_fire;
      s_axi_wready_o  <= ~w_held_reg & ~(s_axi_wvalid_i & s_axi_wready_o) & ~s_axi_bvalid_o & ~wr_fire;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= PPIM_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? PPIM_RESP_OKAY : PPIM_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ******************************************
  // output image registers
  // ******************************************
  logic wr_en;
  // a refused write changes nothing, not even the interrupt status
  assign wr_en = wr_fire & wr_hit & w_strb_reg[0];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      red_reg   <= PPIM_RST_BYTE;
      green_reg <= PPIM_RST_BYTE;
      blue_reg  <= PPIM_RST_BYTE;
      dout_reg  <= PPIM_RST_BYTE;
    end else if (wr_en) begin
      if (aw_addr_reg == PPIM_A_LED_RED)    red_reg   <= w_data_reg[7:0];  // [RULE4]
      if (aw_addr_reg == PPIM_A_LED_GREEN)  green_reg <= w_data_reg[7:0];  // [RULE4]
      if (aw_addr_reg == PPIM_A_LED_BLUE)   blue_reg  <= w_data_reg[7:0];  // [RULE4]
      if (aw_addr_reg == PPIM_A_DIG_OUTPUT) dout_reg  <= w_data_reg[7:0];  // [RULE4]
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_safe_out
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        safe_out_reg[8*g +: 8] <= PPIM_RST_BYTE;
      end else if (wr_en && aw_addr_reg == PPIM_A_SAFE_OUT0 + 8'(4*g)) begin
        safe_out_reg[8*g +: 8] <= w_data_reg[7:0];               // [RULE7]
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg      <= PPIM_RST_CFG;
      irq_mask_reg <= PPIM_RST_MASK;
    end else if (wr_fire) begin
      if (aw_addr_reg == PPIM_A_CONFIG && w_strb_reg[0]) cfg_reg[7:0]  <= w_data_reg[7:0];
      if (aw_addr_reg == PPIM_A_CONFIG && w_strb_reg[1]) cfg_reg[15:8] <= w_data_reg[15:8];
      if (aw_addr_reg == PPIM_A_IRQ_MASK && wr_en) irq_mask_reg <= w_data_reg[PPIM_IRQ_W-1:0];
    end
  end

  // ******************************************
  // drive outputs
  // ******************************************
  ppim_led_decode #(.NUM_LEDS(8)) u_led (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .red_i   (red_reg),
    .green_i (green_reg),
    .blue_i  (blue_reg),
    .color_o (led_color_o)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      digital_output_o <= PPIM_RST_BYTE;
      safety_output_o  <= 32'h0000_0000;
    end else begin
      digital_output_o <= dout_reg & ~safe_assign;               // [RULE6] [RULE12]
      safety_output_o  <= safe_out_reg;                          // [RULE1]
    end
  end

  // ******************************************
  // interrupts
  // ******************************************
  logic [PPIM_IRQ_W-1:0] irq_event;
  logic [PPIM_IRQ_W-1:0] irq_clear;

  assign irq_event[PPIM_IRQ_KEY_BIT]  = key_img_reg != key_sync;
  assign irq_event[PPIM_IRQ_DIN_BIT]  = din_img_reg != (din_sync & ~safe_assign);
  assign irq_event[PPIM_IRQ_SAFE_BIT] = safe_img_reg != safe_img_next;
  assign irq_event[PPIM_IRQ_OUT_BIT]  = wr_en && aw_addr_reg >= PPIM_A_LED_RED && aw_addr_reg <= PPIM_A_DIG_OUTPUT;
  assign irq_clear = (wr_en && aw_addr_reg == PPIM_A_IRQ_STATUS) ? w_data_reg[PPIM_IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_reg <= '0;
      irq_o        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
      irq_o        <= |(((irq_stat_reg & ~irq_clear) | irq_event) & irq_mask_reg);
    end
  end

  // ******************************************
  // axi4-lite read channel
  // ******************************************
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr_i)
      PPIM_A_KEY_STATE:  rd_data[7:0] = key_img_reg;
      PPIM_A_DIG_INPUT:  rd_data[7:0] = din_img_reg;
      PPIM_A_SAFE_IN0:   rd_data[7:0] = safe_img_reg;
      PPIM_A_SAFE_IN1, PPIM_A_SAFE_IN2, PPIM_A_SAFE_IN3, PPIM_A_SAFE_IN4: rd_data = 32'h0000_0000;
      PPIM_A_LED_RED:    rd_data[7:0] = red_reg;
      PPIM_A_LED_GREEN:  rd_data[7:0] = green_reg;
      PPIM_A_LED_BLUE:   rd_data[7:0] = blue_reg;
      PPIM_A_DIG_OUTPUT: rd_data[7:0] = dout_reg;
      PPIM_A_SAFE_OUT0:  rd_data[7:0] = safe_out_reg[7:0];
      PPIM_A_SAFE_OUT1:  rd_data[7:0] = safe_out_reg[15:8];
      PPIM_A_SAFE_OUT2:  rd_data[7:0] = safe_out_reg[23:16];
      PPIM_A_SAFE_OUT3:  rd_data[7:0] = safe_out_reg[31:24];
      PPIM_A_CONFIG:     rd_data[15:0] = cfg_reg;
      PPIM_A_IRQ_STATUS: rd_data[PPIM_IRQ_W-1:0] = irq_stat_reg;
      PPIM_A_IRQ_MASK:   rd_data[PPIM_IRQ_W-1:0] = irq_mask_reg;
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= PPIM_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_data;
      s_axi_rresp_o   <= rd_hit ? PPIM_RESP_OKAY : PPIM_RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) s_axi_rvalid_o <= 1'b0;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // ******************************************
  // checks
  // ******************************************
  chk_safe_unused_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE8]
    (safe_img_reg & 8'hCE) == 8'h00) else $error("unused fail-safe bits not zero");
  chk_no_eval_empty: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE9]
    (eval_mode == PPIM_EVAL_NONE) |=> ($past(eval_mode) != PPIM_EVAL_NONE || safe_img_reg == 8'h00))
    else $error("fail-safe byte not empty without evaluation");
  chk_single_map: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE10]
    (eval_mode == PPIM_EVAL_SINGLE) |=> safe_img_reg[5:4] == $past(safe_sync[1:0]))
    else $error("single channel bits wrong");
  chk_dual_estop: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE11]
    (eval_mode == PPIM_EVAL_DUAL && safe_sync[1:0] != 2'b11) |=> !safe_img_reg[0])
    else $error("estop released on fault or press");
  chk_key_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE2]
    1'b1 |=> key_img_reg == $past(key_sync)) else $error("key image stale");
  chk_din_masked: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE6]
    (din_img_reg & $past(safe_assign)) == 8'h00) else $error("reserved input leaks");
  sequence red_write_s;
    wr_en && aw_addr_reg == PPIM_A_LED_RED;
  endsequence
  chk_red_plane: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE4]
    red_write_s |=> red_reg == $past(w_data_reg[7:0])) else $error("red plane not stored");
  chk_dout_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)  // [RULE12]
    (wr_en && aw_addr_reg == PPIM_A_DIG_OUTPUT) |=> ##1 digital_output_o == ($past(dout_reg) & ~$past(safe_assign)))
    else $error("digital outputs not applied");
endmodule

// ### ppim_pkg.sv
// package: register map, field positions and reset values of the panel process image block
package ppim_pkg;

  // ******************************************
  // register byte addresses
  // ******************************************
  localparam logic [7:0] PPIM_KEY_STATE_IDX     = 8'h00;
  localparam logic [7:0] PPIM_DIG_INPUT_IDX     = 8'h01;
  localparam logic [7:0] PPIM_LED_RED_IDX       = 8'h00;
  localparam logic [7:0] PPIM_LED_GREEN_IDX     = 8'h01;
  localparam logic [7:0] PPIM_LED_BLUE_IDX      = 8'h02;
  localparam logic [7:0] PPIM_DIG_OUTPUT_IDX    = 8'h03;

  // input side (read) byte addresses
  localparam logic [7:0] PPIM_A_KEY_STATE      = 8'h00;
  localparam logic [7:0] PPIM_A_DIG_INPUT      = 8'h04;
  localparam logic [7:0] PPIM_A_SAFE_IN0       = 8'h08;
  localparam logic [7:0] PPIM_A_SAFE_IN1       = 8'h0C;
  localparam logic [7:0] PPIM_A_SAFE_IN2       = 8'h10;
  localparam logic [7:0] PPIM_A_SAFE_IN3       = 8'h14;
  localparam logic [7:0] PPIM_A_SAFE_IN4       = 8'h18;
  // output side (write, readback) byte addresses
  localparam logic [7:0] PPIM_A_LED_RED        = 8'h20;
  localparam logic [7:0] PPIM_A_LED_GREEN      = 8'h24;
  localparam logic [7:0] PPIM_A_LED_BLUE       = 8'h28;
  localparam logic [7:0] PPIM_A_DIG_OUTPUT     = 8'h2C;
  localparam logic [7:0] PPIM_A_SAFE_OUT0      = 8'h30;
  localparam logic [7:0] PPIM_A_SAFE_OUT1      = 8'h34;
  localparam logic [7:0] PPIM_A_SAFE_OUT2      = 8'h38;
  localparam logic [7:0] PPIM_A_SAFE_OUT3      = 8'h3C;
  // control and interrupt
  localparam logic [7:0] PPIM_A_CONFIG         = 8'h40;
  localparam logic [7:0] PPIM_A_IRQ_STATUS     = 8'h44;
  localparam logic [7:0] PPIM_A_IRQ_MASK       = 8'h48;

  // ******************************************
  // fields
  // ******************************************
  localparam int PPIM_CFG_MODE_LSB      = 0;   // evaluation mode, 2 bits
  localparam int PPIM_CFG_ASSIGN_LSB    = 8;   // inputs reserved for fail-safe, 8 bits
  localparam int PPIM_SAFE_ESTOP_BIT    = 0;
  localparam int PPIM_SAFE_ZERO_BIT     = 4;
  localparam int PPIM_SAFE_ONE_BIT      = 5;
  localparam int PPIM_IRQ_KEY_BIT       = 0;
  localparam int PPIM_IRQ_DIN_BIT       = 1;
  localparam int PPIM_IRQ_SAFE_BIT      = 2;
  localparam int PPIM_IRQ_OUT_BIT       = 3;
  localparam int PPIM_IRQ_W             = 4;

  // ******************************************
  // reset values
  // ******************************************
  localparam logic [7:0]  PPIM_RST_BYTE  = 8'h00;
  localparam logic [15:0] PPIM_RST_CFG   = 16'h0000;
  localparam logic [3:0]  PPIM_RST_MASK  = 4'h0;

  // ******************************************
  // evaluation modes and colours
  // ******************************************
  typedef enum logic [1:0] {
    PPIM_EVAL_NONE   = 2'h0,
    PPIM_EVAL_SINGLE = 2'h1,
    PPIM_EVAL_DUAL   = 2'h2
  } ppim_eval_t;

  typedef enum logic [2:0] {
    PPIM_LED_OFF    = 3'h0,
    PPIM_LED_RED    = 3'h1,
    PPIM_LED_GREEN  = 3'h2,
    PPIM_LED_BLUE   = 3'h3,
    PPIM_LED_YELLOW = 3'h4,
    PPIM_LED_WHITE  = 3'h5
  } ppim_color_t;

  // axi response codes
  localparam logic [1:0] PPIM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPIM_RESP_SLVERR = 2'h2;

endpackage

// ### ppim_sync.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module ppim_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage_reg;

  initial begin
    if (WIDTH < 1) $error("ppim_sync: WIDTH must be at least 1");
  end

  // first stage is read only by the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_reg <= '0;
      sync_o    <= '0;
    end else begin
      stage_reg <= async_i;
      sync_o    <= stage_reg;
    end
  end
endmodule

// ### ppim_led_decode.sv
// registered rgb plane decoder for the tricolour key leds
`timescale 1ns/1ps
module ppim_led_decode
  import ppim_pkg::*;
#(
  parameter int NUM_LEDS = 8
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // planes
  input  wire logic [NUM_LEDS-1:0]   red_i,
  input  wire logic [NUM_LEDS-1:0]   green_i,
  input  wire logic [NUM_LEDS-1:0]   blue_i,
  // drive: one colour per led, 3 bits each
  output logic      [3*NUM_LEDS-1:0] color_o
);
  initial begin
    if (NUM_LEDS < 1) $error("ppim_led_decode: NUM_LEDS must be at least 1");
  end

  function automatic ppim_color_t rgb_color(input logic [2:0] rgb);
    unique case (rgb)
      3'b100:  rgb_color = PPIM_LED_RED;
      3'b010:  rgb_color = PPIM_LED_GREEN;
      3'b001:  rgb_color = PPIM_LED_BLUE;
      3'b110:  rgb_color = PPIM_LED_YELLOW;
      3'b111:  rgb_color = PPIM_LED_WHITE;
      default: rgb_color = PPIM_LED_OFF;  // 000, 101 and 011 stay dark
    endcase
  endfunction

  for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        color_o[3*g +: 3] <= PPIM_LED_OFF;
      end else begin
        color_o[3*g +: 3] <= rgb_color({red_i[g], green_i[g], blue_i[g]});  // [RULE5]
      end
    end
  end
endmodule

// ### ppim_panel_model.sv
// panel model: keys, standard inputs and a two-contact emergency stop
`timescale 1ns/1ps
module ppim_panel_model (
  // commands from the bench
  input  wire logic [7:0] keys_i,
  input  wire logic [7:0] din_i,
  input  wire logic [1:0] stop_i,
  // panel pins
  output logic      [7:0] key_pin_o,
  output logic      [7:0] din_pin_o,
  output logic            contact0_o,
  output logic            contact1_o
);
  // stop_i: 0 released, 1 pressed, 2 one contact stuck closed
  assign key_pin_o  = keys_i;
  assign din_pin_o  = din_i;
  // both contacts close only while released; a fault is a discrepancy
  assign contact0_o = (stop_i == 2'h0) || (stop_i == 2'h2);
  assign contact1_o = (stop_i == 2'h0);
endmodule

// ### panel_process_image_map_test.sv
// testbench: axi4-lite access to the panel process image block
`timescale 1ns/1ps
module panel_process_image_map_test
  import ppim_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, keys = 8'h00, din = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, c0, c1;
  logic [1:0]  bresp, rresp, r, stop = 2'h0;
  logic [31:0] rdata, safe_out;
  logic [23:0] color;
  logic [7:0]  kpin, dpin, dout;
  int          num_errors = 0;
  int          compares = 0;

  always #12.5 clk_i = ~clk_i;

  ppim_panel_model ppim_panel_model_inst (.keys_i(keys), .din_i(din), .stop_i(stop),
    .key_pin_o(kpin), .din_pin_o(dpin), .contact0_o(c0), .contact1_o(c1));

  ppim_top ppim_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .key_pin_i(kpin), .standard_input_bit_i(dpin), .safety_input_zero_i(c0),
    .safety_input_one_i(c1), .led_color_o(color), .digital_output_o(dout),
    .safety_output_o(safe_out), .irq_o(irq));

  // ******************************************
  // bus tasks
  // ******************************************
  // each channel is released at the edge where its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat  = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask

  // pins pass two synchroniser stages and the image register
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ******************************************
  // tests
  // ******************************************
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(PPIM_A_LED_RED, d, r);
    chk_val(d, 32'h0);
    keys <= 8'hA5;
    din  <= 8'h3C;
    settle();
    rd(PPIM_A_KEY_STATE, d, r);
    chk_val(d, 32'hA5);
    rd(PPIM_A_DIG_INPUT, d, r);
    chk_val(d, 32'h3C);
    rd(PPIM_A_SAFE_IN0, d, r);
    chk_val(d, 32'h0);
    $display("test inputs done");
    // led g gets rgb pattern g, so all eight combinations appear at once
    wr(PPIM_A_LED_RED, 32'hF0, r);
    wr(PPIM_A_LED_GREEN, 32'hCC, r);
    wr(PPIM_A_LED_BLUE, 32'hAA, r);
    wr(PPIM_A_DIG_OUTPUT, 32'h5A, r);
    repeat (3) @(posedge clk_i);
    chk_val({8'h0, color}, 32'hB01098);
    chk_val({24'h0, dout}, 32'h5A);
    rd(PPIM_A_LED_GREEN, d, r);
    chk_val(d, 32'hCC);
    $display("test outputs done");
    wr(PPIM_A_CONFIG, 32'h0F01, r);
    wr(PPIM_A_DIG_OUTPUT, 32'h5A, r);
    stop <= 2'h2;
    settle();
    chk_val({24'h0, dout}, 32'h50);
    rd(PPIM_A_DIG_INPUT, d, r);
    chk_val(d, 32'h30);
    rd(PPIM_A_SAFE_IN0, d, r);
    chk_val(d, 32'h10);
    wr(PPIM_A_CONFIG, 32'h0F02, r);
    for (int i = 0; i < 3; i++) begin
      stop <= 2'(i);
      settle();
      rd(PPIM_A_SAFE_IN0, d, r);
      chk_val(d, (i == 0) ? 32'h1 : 32'h0);
    end
    wr(PPIM_A_SAFE_OUT3, 32'h81, r);
    repeat (2) @(posedge clk_i);
    chk_val(safe_out, 32'h8100_0000);
    rd(PPIM_A_SAFE_IN4, d, r);
    chk_resp(r, PPIM_RESP_OKAY);
    rd(8'h1C, d, r);
    chk_resp(r, PPIM_RESP_SLVERR);
    wr(PPIM_A_KEY_STATE, 32'hFF, r);
    chk_resp(r, PPIM_RESP_SLVERR);
    $display("test fail-safe done");
    wr(PPIM_A_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq}, 32'h0);
    wr(PPIM_A_IRQ_MASK, 32'hF, r);
    repeat (2) @(posedge clk_i);
    chk_val({31'h0, irq}, 32'h1);
    // key, input, fail-safe byte and output write events have all occurred by now
    rd(PPIM_A_IRQ_STATUS, d, r);
    chk_val(d, 32'hF);
    wr(PPIM_A_IRQ_STATUS, 32'hF, r);
    repeat (2) @(posedge clk_i);
    rd(PPIM_A_IRQ_STATUS, d, r);
    chk_val(d, 32'h0);
    chk_val({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wrap_up();
  end

  // the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule
